// file: rtl/sso_core.sv
// Function
// - Clamp needs speed mode, input, low speed
// - Analog, bit clear: raw command, hold position
// - Register, bit clear: ramped command, position lock
// - Analog, bit set: S-curve to zero
// - Register, bit set: speed forced zero
// - Inhibit off: pulses in pulse-position mode always accepted
// - Inhibit on: limit blocks its direction
// - Inhibit on, both limits active: all pulses blocked
// - Phase-loss detection unless bit set
// - Encoder fault detection unless bit set
// - Torque sign from pass/invert inputs
// - Torque source from two selectors
// - Speed limit from selectors, four settings
// - Code 0x10 makes speed limit permanent
// - Undervoltage latched or auto cleared
// - Option bit hides temperature warning
// - Undervoltage goes to warn or alarm
// - Phase loss goes to alarm or warn
// - Single-phase count, four edges each
// - Direct count, edges as given
//
// The Avalon-MM register port is this design's own decision.
module sso_core #(
    parameter int TW = 16,   // Torque word width
    parameter int SW = 16,   // Speed word width
    parameter int EW = 16    // Encoder parameter width
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_n,
    // Avalon-MM slave
    input  wire logic [11:0]           i_avs_address,
    input  wire logic                  i_avs_read,
    input  wire logic                  i_avs_write,
    input  wire logic [31:0]           i_avs_writedata,
    input  wire logic [3:0]            i_avs_byteenable,
    output logic      [31:0]           o_avs_readdata,
    output logic                       o_avs_waitrequest,
    // Drive side
    input  wire sso_pkg::sso_in_t      i_in,
    input  wire logic [SW-1:0]         i_motor_speed,
    input  wire logic [SW-1:0]         i_zero_speed_threshold_param,
    input  wire logic [SW-1:0]         i_analog_speed_cmd,
    input  wire logic [SW-1:0]         i_ramped_reg_speed_cmd,
    input  wire logic [7:0]            i_speed_torque_limit_param,
    input  wire logic signed [TW-1:0]  i_torque_src [4],
    input  wire logic [EW-1:0]         i_encoder_output_pulse_param,
    output sso_pkg::sso_ctl_t          o_ctl,
    output logic signed [TW-1:0]       o_torque_cmd,
    output logic [1:0]                 o_torque_src_idx,
    output logic [EW+1:0]              o_encoder_edges_per_rev
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [15:0]            opt_one;   // Special options word one
        logic [15:0]            opt_two;   // Special options word two
        sso_pkg::sso_in_t       in;        // Sampled inputs
        logic                   uv_latch;  // Latched undervoltage error
        logic                   ack;       // Bus answer pending
        logic [31:0]            rdata;
        sso_pkg::sso_ctl_t      ctl;
        logic signed [TW-1:0]   torque;
        logic [1:0]             tsrc;
        logic [EW+1:0]          enc;
    } sso_state_t;

    sso_state_t st_q;   // Registered state
    sso_state_t st_d;   // Next state

    logic [1:0] tsel;   // Torque source index from sampled inputs

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        logic clamp;
        logic spd_low;
        logic uv_now;
        logic ph_now;
        logic ef_now;
        logic req;
        clamp   = 1'b0;
        spd_low = 1'b0;
        uv_now  = 1'b0;
        ph_now  = 1'b0;
        ef_now  = 1'b0;
        req     = 1'b0;
        st_d    = st_q;
        tsel    = {st_q.in.torque_source_sel_hi, st_q.in.torque_source_sel_lo};

        // sample inputs first
        // Gating uses last cycle's sample, so inputs are stable for the decision
        st_d.in = i_in;

        // Bus: one wait cycle then answer; waitrequest low for one edge
        req = (i_avs_read || i_avs_write) && !st_q.ack;
        st_d.ack = req;
        // Write lands on the edge that sees waitrequest low, never while it is high
        if (st_q.ack && i_avs_write) begin
            unique case (i_avs_address)
                sso_pkg::ADDR_OPT_ONE: begin
                    if (i_avs_byteenable[0]) st_d.opt_one[7:0]  = i_avs_writedata[7:0];
                    if (i_avs_byteenable[1]) st_d.opt_one[15:8] = i_avs_writedata[15:8];
                end
                sso_pkg::ADDR_OPT_TWO: begin
                    if (i_avs_byteenable[0]) st_d.opt_two[7:0]  = i_avs_writedata[7:0];
                    if (i_avs_byteenable[1]) st_d.opt_two[15:8] = i_avs_writedata[15:8];
                end
                sso_pkg::ADDR_UV_CLEAR: begin
                    // Clear only; a still present condition re-sets below
                    if (i_avs_byteenable[0] && i_avs_writedata[0]) st_d.uv_latch = 1'b0;
                end
                default: begin
                    // Unmapped write ignored
                end
            endcase
        end
        st_d.rdata = 32'h0000_0000;
        if (req && i_avs_read) begin
            unique case (i_avs_address)
                sso_pkg::ADDR_OPT_ONE: st_d.rdata = {16'h0000, st_q.opt_one};
                sso_pkg::ADDR_OPT_TWO: st_d.rdata = {16'h0000, st_q.opt_two};
                sso_pkg::ADDR_STATUS: begin
                    st_d.rdata[sso_pkg::ST_CLAMP] = st_q.ctl.clamp_active;
                    st_d.rdata[sso_pkg::ST_UV]    = st_q.ctl.undervoltage_alarm;
                    st_d.rdata[sso_pkg::ST_PHASE] = st_q.ctl.phase_loss_alarm;
                    st_d.rdata[sso_pkg::ST_ENCF]  = st_q.ctl.encoder_output_fault_alarm;
                    st_d.rdata[sso_pkg::ST_WARN]  = st_q.ctl.warn_output;
                    st_d.rdata[sso_pkg::ST_ALARM] = st_q.ctl.alarm_output;
                    st_d.rdata[sso_pkg::ST_TEMP]  = st_q.ctl.temp_warn_disp;
                end
                default: st_d.rdata = 32'h0000_0000;  // Unmapped reads zero
            endcase
        end

        if (st_q.in.analog_source) begin
            spd_low = i_analog_speed_cmd < i_zero_speed_threshold_param;
        end else begin
            spd_low = i_ramped_reg_speed_cmd < i_zero_speed_threshold_param;
        end
        if (i_motor_speed >= i_zero_speed_threshold_param) spd_low = 1'b0;
        clamp = st_q.in.speed_mode && st_q.in.zero_speed_clamp_input && spd_low;
        st_d.ctl.clamp_active  = clamp;
        st_d.ctl.position_lock = clamp && !st_q.opt_one[sso_pkg::B1_CLAMP_SEL];
        st_d.ctl.s_curve_decel = clamp && st_q.opt_one[sso_pkg::B1_CLAMP_SEL]
                               && st_q.in.analog_source;
        st_d.ctl.speed_force_zero = clamp && st_q.opt_one[sso_pkg::B1_CLAMP_SEL]
                                  && !st_q.in.analog_source;

        st_d.ctl.pulse_fwd = st_q.in.cmd_pulse && st_q.in.pulse_position_mode;
        st_d.ctl.pulse_neg = st_q.in.cmd_dir_neg;
        if (st_q.opt_one[sso_pkg::B1_PULSE_INH]) begin
            if (st_q.in.cmd_dir_neg && st_q.in.negative_limit_input) st_d.ctl.pulse_fwd = 1'b0;
            if (!st_q.in.cmd_dir_neg && st_q.in.positive_limit_input) st_d.ctl.pulse_fwd = 1'b0;
        end

        ph_now = st_q.in.phase_loss_raw && !st_q.opt_one[sso_pkg::B1_PHASE_DIS];
        ef_now = st_q.in.encoder_fault_raw && !st_q.opt_one[sso_pkg::B1_ENCF_DIS];
        st_d.ctl.phase_loss_alarm           = ph_now;
        st_d.ctl.encoder_output_fault_alarm = ef_now;

        // latch or auto clear; set wins over clear
        if (st_q.in.undervoltage_raw) begin
            st_d.uv_latch = 1'b1;
        end else if (st_q.opt_two[sso_pkg::B2_UV_AUTO]) begin
            st_d.uv_latch = 1'b0;
        end
        uv_now = st_d.uv_latch;
        st_d.ctl.undervoltage_alarm = uv_now;

        st_d.ctl.warn_output  = (uv_now && !st_q.opt_two[sso_pkg::B2_UV_ALARM])
                              || (ph_now && st_q.opt_two[sso_pkg::B2_PHASE_WARN]);
        st_d.ctl.alarm_output = (uv_now && st_q.opt_two[sso_pkg::B2_UV_ALARM])
                              || (ph_now && !st_q.opt_two[sso_pkg::B2_PHASE_WARN])
                              || ef_now;

        st_d.ctl.temp_warn_disp = st_q.in.motor_temp_raw
                                && !st_q.opt_two[sso_pkg::B2_TEMP_HIDE];

        st_d.ctl.speed_limit_idx = {st_q.in.speed_sel_hi, st_q.in.speed_sel_lo};
        st_d.ctl.speed_limit_en = st_q.in.speed_limit_switch_input
                                || (i_speed_torque_limit_param == sso_pkg::SPD_LIMIT_ALWAYS);

        st_d.tsrc = tsel;
        unique case ({st_q.in.torque_pass_input, st_q.in.torque_invert_input})
            2'b10:   st_d.torque = i_torque_src[tsel];
            2'b01:   st_d.torque = -i_torque_src[tsel];
            default: st_d.torque = '0;  // Both on or both off
        endcase

        if (st_q.opt_two[sso_pkg::B2_ENC_DIRECT]) begin
            st_d.enc = {2'b00, i_encoder_output_pulse_param};
        end else begin
            st_d.enc = {i_encoder_output_pulse_param, 2'b00};  // Times ENC_QUAD
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_q         <= '0;
            st_q.opt_one <= sso_pkg::RST_OPT_ONE;
            st_q.opt_two <= sso_pkg::RST_OPT_TWO;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from state flip-flops
    assign o_avs_readdata          = st_q.rdata;
    assign o_avs_waitrequest       = !st_q.ack;
    assign o_ctl                   = st_q.ctl;
    assign o_torque_cmd            = st_q.torque;
    assign o_torque_src_idx        = st_q.tsrc;
    assign o_encoder_edges_per_rev = st_q.enc;
endmodule : sso_core

// file: inc/sso_pkg.sv
package sso_pkg;
    // ************************************************************
    // Register map (byte addresses, one word each)
    // ************************************************************
    localparam logic [11:0] ADDR_OPT_TWO   = 12'h284;  // Special options word two
    localparam logic [11:0] ADDR_OPT_ONE   = 12'h282;  // Special options word one
    localparam logic [11:0] ADDR_STATUS    = 12'h300;  // Live status word
    localparam logic [11:0] ADDR_UV_CLEAR  = 12'h304;  // Undervoltage clear strobe
    localparam logic [15:0] RST_OPT_TWO    = 16'h0000; // Word two reset value
    localparam logic [15:0] RST_OPT_ONE    = 16'h0000; // Word one reset value

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int B1_CLAMP_SEL   = 10;  // Clamp decision selection
    localparam int B1_PULSE_INH   = 11;  // Limit pulse inhibit
    localparam int B1_PHASE_DIS   = 12;  // Phase-loss detection off
    localparam int B1_ENCF_DIS    = 13;  // Encoder-output fault detection off
    localparam int B2_UV_AUTO     = 2;   // Undervoltage auto clear
    localparam int B2_TEMP_HIDE   = 7;   // Hide motor temperature warning
    localparam int B2_UV_ALARM    = 9;   // Undervoltage to alarm output
    localparam int B2_PHASE_WARN  = 12;  // Phase loss to warning output
    localparam int B2_ENC_DIRECT  = 15;  // Encoder count given directly

    // Status bit positions
    localparam int ST_CLAMP = 0;
    localparam int ST_UV    = 1;
    localparam int ST_PHASE = 2;
    localparam int ST_ENCF  = 3;
    localparam int ST_WARN  = 4;
    localparam int ST_ALARM = 5;
    localparam int ST_TEMP  = 6;

    localparam logic [7:0] SPD_LIMIT_ALWAYS = 8'h10; // Permanent speed limit code
    localparam int         ENC_QUAD         = 4;     // Edges per single-phase pulse

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic        pulse_position_mode;
        logic        speed_mode;
        logic        cmd_pulse;     // One command pulse this cycle
        logic        cmd_dir_neg;   // Direction of that pulse
        logic        negative_limit_input;
        logic        positive_limit_input;
        logic        zero_speed_clamp_input;
        logic        torque_pass_input;
        logic        torque_invert_input;
        logic        torque_source_sel_lo;
        logic        torque_source_sel_hi;
        logic        speed_sel_lo;
        logic        speed_sel_hi;
        logic        speed_limit_switch_input;
        logic        analog_source;
        logic        undervoltage_raw;
        logic        phase_loss_raw;
        logic        encoder_fault_raw;
        logic        motor_temp_raw;
    } sso_in_t;

    typedef struct packed {
        logic        pulse_fwd;     // Pulse passed forward
        logic        pulse_neg;     // Direction of passed pulse
        logic        clamp_active;
        logic        position_lock;
        logic        s_curve_decel;
        logic        speed_force_zero;
        logic        speed_limit_en;
        logic [1:0]  speed_limit_idx;
        logic        warn_output;   // Function code 0x11
        logic        alarm_output;  // Function code 0x07
        logic        temp_warn_disp;
        logic        undervoltage_alarm;
        logic        phase_loss_alarm;
        logic        encoder_output_fault_alarm;
    } sso_ctl_t;
endpackage : sso_pkg

// file: dv/sso_host_model.sv
// ************************************************************
// Host controller model: pulse commands, inputs, sources
// ************************************************************
module sso_host_model (
    input  wire logic          i_clk,
    input  wire logic          i_en,
    output sso_pkg::sso_in_t   o_in,
    output logic signed [15:0] o_tsrc [4],
    output logic [15:0]        o_spd [4]
);
    timeunit 1ns;
    timeprecision 1ps;
    int seed = 15541;  // Fixed seed, repeatable traffic

    // Quiet levels at start; only o_in stays quiet until the bench enables traffic
    initial begin
        o_in = '0;
        foreach (o_tsrc[k]) o_tsrc[k] = 16'sh0000;
        foreach (o_spd[k]) o_spd[k] = 16'h0000;
    end

    // New levels each cycle; a command pulse lasts one cycle only
    always @(posedge i_clk) begin
        o_in <= i_en ? 19'($random(seed)) : 19'h00000;
        for (int k = 0; k < 4; k++) begin
            o_tsrc[k] <= 16'($random(seed));
            // Small speeds so the clamp threshold is crossed often
            o_spd[k] <= {8'h00, 8'($random(seed))};
        end
    end
endmodule // sso_host_model

// file: dv/sso_core_chk.sv
// ************************************************************
// Option logic checker
// ************************************************************
module sso_core_chk (
    input wire logic              i_clk,
    input wire logic              i_rst_n,
    input wire logic [11:0]       i_avs_address,
    input wire logic              i_avs_write,
    input wire logic [31:0]       i_avs_writedata,
    input wire logic              o_avs_waitrequest,
    input wire sso_pkg::sso_in_t  i_in,
    input wire logic [7:0]        i_speed_torque_limit_param,
    input wire logic [15:0]       i_encoder_output_pulse_param,
    input wire sso_pkg::sso_ctl_t o_ctl,
    input wire logic [17:0]       o_encoder_edges_per_rev
);
    logic [15:0] opt1_q;   // Shadow of word one
    logic [15:0] opt2_q;   // Shadow of word two
    logic [2:0]  quiet_q;  // Cycles since a write; options must settle first
    wire logic   wr = i_avs_write && !o_avs_waitrequest;
    wire logic   ok = quiet_q == 3'h7;
    wire logic   pp = i_in.cmd_pulse && i_in.pulse_position_mode;

    // Shadow the option words as writes complete
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || wr) quiet_q <= 3'h0;
        else if (!ok) quiet_q <= quiet_q + 3'h1;
        if (!i_rst_n) opt1_q <= 16'h0000;
        else if (wr && i_avs_address == sso_pkg::ADDR_OPT_ONE) opt1_q <= i_avs_writedata[15:0];
        if (!i_rst_n) opt2_q <= 16'h0000;
        else if (wr && i_avs_address == sso_pkg::ADDR_OPT_TWO) opt2_q <= i_avs_writedata[15:0];
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_pulse_free_pass : assert property (
        ok && !opt1_q[11] && $past(pp, 2) |-> o_ctl.pulse_fwd) else $error("pulse dropped");
    a_limit_gate_dir : assert property (
        ok && opt1_q[11] && $past(pp, 2) |-> o_ctl.pulse_fwd == $past(!(i_in.cmd_dir_neg ?
        i_in.negative_limit_input : i_in.positive_limit_input), 2)) else $error("limit gate");
    a_speed_limit_on : assert property (
        ok && $past(i_speed_torque_limit_param == sso_pkg::SPD_LIMIT_ALWAYS, 1)
        |-> o_ctl.speed_limit_en) else $error("speed limit not permanent");
    a_phase_detect : assert property (
        ok && $past(i_in.phase_loss_raw, 2) |-> o_ctl.phase_loss_alarm == !opt1_q[12])
        else $error("phase-loss detection wrong");
    a_encf_detect : assert property (
        ok && $past(i_in.encoder_fault_raw, 2)
        |-> o_ctl.encoder_output_fault_alarm == !opt1_q[13]) else $error("encoder fault wrong");
    a_uv_route : assert property (
        ok && $past(i_in.undervoltage_raw, 2)
        |-> (opt2_q[9] ? o_ctl.alarm_output : o_ctl.warn_output)) else $error("uv route");
    a_phase_route : assert property (
        ok && !opt1_q[12] && $past(i_in.phase_loss_raw, 2)
        |-> (opt2_q[12] ? o_ctl.warn_output : o_ctl.alarm_output)) else $error("phase route");
    a_enc_scale : assert property (
        ok |-> o_encoder_edges_per_rev == (opt2_q[15] ? {2'b00, $past(i_encoder_output_pulse_param,
        1)} : {$past(i_encoder_output_pulse_param, 1), 2'b00})) else $error("encoder scale");
endmodule // sso_core_chk

bind sso_core sso_core_chk u_chk (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_in(i_in), .o_ctl(o_ctl),
    .i_speed_torque_limit_param(i_speed_torque_limit_param),
    .i_encoder_output_pulse_param(i_encoder_output_pulse_param),
    .o_encoder_edges_per_rev(o_encoder_edges_per_rev)
);

// file: dv/tb_servo_special_option_bits.sv
// ************************************************************
// Testbench
// ************************************************************
module tb_servo_special_option_bits;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk, rst_n, avs_rd, avs_wr, avs_wait, host_en, run;
    logic [11:0]        avs_addr;
    logic [31:0]        avs_wdata, avs_rdata, rd;
    logic [3:0]         faults;        // Fault raws forced by the bench
    logic [7:0]         stl;
    logic [15:0]        enc, opt1, opt2;
    sso_pkg::sso_in_t   host_in, dut_in, prev_in;
    sso_pkg::sso_ctl_t  ctl;
    logic signed [15:0] tsrc [4];
    logic [15:0]        spd [4];
    logic signed [15:0] tq;
    logic [1:0]         tidx;
    logic [17:0]        edges;
    logic [44:0]        q [$];         // Expected results in flight
    logic [44:0]        exp_v, got_v;  // Popped expectation and live outputs
    int                 miscompares, total_checks;
    assign dut_in = {host_in[18:4], faults};
    assign got_v = {ctl.pulse_fwd, tq, tidx, edges, ctl.pulse_neg, ctl.clamp_active,
        ctl.position_lock, ctl.s_curve_decel, ctl.speed_force_zero, ctl.speed_limit_en,
        ctl.speed_limit_idx};

    sso_host_model u_host (.i_clk(clk), .i_en(host_en), .o_in(host_in), .o_tsrc(tsrc),
        .o_spd(spd));
    sso_core u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_avs_address(avs_addr), .i_avs_read(avs_rd),
        .i_avs_write(avs_wr), .i_avs_writedata(avs_wdata), .i_avs_byteenable(4'h3),
        .o_avs_readdata(avs_rdata), .o_avs_waitrequest(avs_wait), .i_in(dut_in),
        .i_motor_speed(spd[0]), .i_zero_speed_threshold_param(spd[1]),
        .i_analog_speed_cmd(spd[2]), .i_ramped_reg_speed_cmd(spd[3]),
        .i_speed_torque_limit_param(stl), .i_torque_src(tsrc), .o_ctl(ctl),
        .i_encoder_output_pulse_param(enc), .o_torque_cmd(tq), .o_torque_src_idx(tidx),
        .o_encoder_edges_per_rev(edges));

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [44:0] exp, input logic [44:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One bus cycle; held until waitrequest is sampled low or 64 cycles have passed
    task automatic bus(input logic wr, input logic [11:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_addr <= a;
        avs_wdata <= {16'h0000, d};
        avs_wr <= wr;
        avs_rd <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_wait !== 1'b0 && n < 64);
        rd = avs_rdata;
        if (n >= 64) miscompares++;
        avs_wr <= 1'b0;
        avs_rd <= 1'b0;
    endtask

    // Reference: torque sign, pulse gate, encoder scale
    function automatic logic [44:0] model(sso_pkg::sso_in_t x);
        logic signed [15:0] t;
        logic               p, c, s;
        logic [15:0]        v;
        t = tsrc[{x.torque_source_sel_hi, x.torque_source_sel_lo}];
        if (x.torque_pass_input == x.torque_invert_input) t = 16'sh0000;
        else if (x.torque_invert_input) t = -t;
        p = x.cmd_pulse && x.pulse_position_mode;
        if (opt1[11] && (x.cmd_dir_neg ? x.negative_limit_input : x.positive_limit_input)) p = 0;
        // Clamp: speed mode, input, command and motor both below threshold
        v = x.analog_source ? spd[2] : spd[3];
        c = x.speed_mode && x.zero_speed_clamp_input && v < spd[1] && spd[0] < spd[1];
        s = opt1[10];
        return {p, t, x.torque_source_sel_hi, x.torque_source_sel_lo,
                opt2[15] ? {2'b00, enc} : {enc, 2'b00}, x.cmd_dir_neg, c, c && !s,
                c && s && x.analog_source, c && s && !x.analog_source,
                x.speed_limit_switch_input || stl == sso_pkg::SPD_LIMIT_ALWAYS,
                x.speed_sel_hi, x.speed_sel_lo};
    endfunction

    // Pins are sampled one edge, the result shows one edge later; the live
    // torque sources and speeds of that second cycle go into the result
    always @(negedge clk) begin
        if (!run) q.delete();
        else begin
            q.push_back(model(prev_in));
            if (q.size() > 1) begin
                exp_v = q.pop_front();
                chk("drive", exp_v[44:8], got_v[44:8]);
                chk("speed", exp_v[7:0], got_v[7:0]);
            end
        end
        prev_in = dut_in;
    end

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Watchdog far beyond the expected run time
    initial begin
        #100000;
        miscompares++;
        end_sim();
    end

    initial begin
        {rst_n, avs_rd, avs_wr, host_en, run, faults, stl, enc, avs_addr, avs_wdata} = '0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        bus(0, sso_pkg::ADDR_OPT_TWO, 16'h0000);
        chk("opt_two_reset", sso_pkg::RST_OPT_TWO, rd);
        bus(1, 12'h3f0, 16'hffff);
        bus(0, 12'h3f0, 16'h0000);
        chk("unmapped", 0, rd);
        // Sweep option bits; reserved bits always written zero
        for (int cfg = 0; cfg < 16; cfg++) begin
            run = 1'b0;
            host_en <= 1'b0;
            opt1 = 16'(cfg) << 10;
            opt2 = {cfg[0], 2'b00, cfg[1], 2'b00, cfg[2], 1'b0, cfg[3], 4'h0, cfg[2], 2'b00};
            stl <= cfg[0] ? sso_pkg::SPD_LIMIT_ALWAYS : 8'(cfg);
            enc <= {cfg[3:0], 12'h9c4};
            bus(1, sso_pkg::ADDR_OPT_ONE, opt1);
            bus(1, sso_pkg::ADDR_OPT_TWO, opt2);
            bus(0, sso_pkg::ADDR_OPT_ONE, 16'h0000);
            chk("opt_one", opt1, rd);
            host_en <= 1'b1;
            repeat (12) @(posedge clk);
            run = 1'b1;
            repeat (200) @(posedge clk);
        end
        run = 1'b0;
        host_en <= 1'b0;
        // Fault detection and temperature display, suppressed pass first
        for (int b = 1; b >= 0; b--) begin
            bus(1, sso_pkg::ADDR_OPT_ONE, b ? 16'h3000 : 16'h0000);
            bus(1, sso_pkg::ADDR_OPT_TWO, b ? 16'h0080 : 16'h1000);
            repeat (8) @(posedge clk);
            faults <= 4'h7;
            repeat (2) @(posedge clk);
            bus(0, sso_pkg::ADDR_STATUS, 16'h0000);
            chk("fault_status", b ? 0 : 32'h7c, rd & 32'h7c);
            faults <= 4'h0;
        end
        // Undervoltage: latched and cleared, then auto cleared
        for (int a = 0; a < 2; a++) begin
            bus(1, sso_pkg::ADDR_OPT_TWO, a ? 16'h0204 : 16'h0000);
            repeat (8) @(posedge clk);
            faults <= 4'h8;
            repeat (3) @(posedge clk);
            bus(0, sso_pkg::ADDR_STATUS, 16'h0000);
            chk("uv_route", a ? 32'h22 : 32'h12, rd & 32'h32);
            faults <= 4'h0;
            repeat (3) @(posedge clk);
            bus(0, sso_pkg::ADDR_STATUS, 16'h0000);
            chk("uv_held", a ? 0 : 2, rd & 2);
            bus(1, sso_pkg::ADDR_UV_CLEAR, 16'h0001);
            bus(0, sso_pkg::ADDR_STATUS, 16'h0000);
            chk("uv_cleared", 0, rd & 2);
        end
        end_sim();
    end
endmodule // tb_servo_special_option_bits
